// *** hw/bhrd_map.vh ***
// Register offsets, field positions and reset values of the banked host register decode.
`ifndef BHRD_MAP_VH
`define BHRD_MAP_VH
// ----------------------------------------------------------------------------
// Offsets inside a bank (byte offsets of the 32-byte I/O window; address bit 4 is not decoded)
// ----------------------------------------------------------------------------
`define BHRD_OFS_BASE_ADDR       4'h0
`define BHRD_OFS_WATERMARK       4'h4
`define BHRD_OFS_BANK_SEL        4'he
`define BHRD_OFS_BANK_SEL_DW     4'hc
// ----------------------------------------------------------------------------
// Banks and fields
// ----------------------------------------------------------------------------
`define BHRD_BANK_W              6
`define BHRD_BANK_ZERO           6'h00
`define BHRD_BANK_RSVD_FIRST     6'h38
`define BHRD_BASE_RESET          16'h0300
`define BHRD_BASE_RW_MASK        16'hffe0
`define BHRD_WMARK_BIT           12
`define BHRD_WMARK_RESET         1'b0
`define BHRD_EEPROM_BASE_WORD    8'h00
`endif

// *** hw/bhrd_top.v ***
// Host register decode: base address claim, bank select and bank 0 registers.
`timescale 1ns/100ps
`include "bhrd_map.vh"
module bhrd_top #(
  parameter BANK_W = `BHRD_BANK_W
) (
  input  wire               i_sys_clk,
  input  wire               i_nrst,
  input  wire               i_ce,
  input  wire [15:0]        i_addr,
  input  wire [3:0]         i_be,
  input  wire               i_wr,
  input  wire               i_rd,
  input  wire [31:0]        i_wdata,
  input  wire               i_eeprom_load_enable_pin,
  input  wire               i_eeprom_valid,
  input  wire [15:0]        i_eeprom_word0,
  input  wire               i_wmark_event,
  output reg  [31:0]        o_rdata,
  output reg                o_hit,
  output reg  [BANK_W-1:0]  o_bank_choice_field,
  output reg  [15:0]        o_host_base_address,
  output reg                o_wmark_2k,
  output reg                o_load_done
);
  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // The access claims the device when the upper bus bits equal the base.
  wire       hit_w = (i_addr[15:8] == o_host_base_address[15:8]) &&
                     (i_addr[7:5]  == o_host_base_address[7:5]);
  wire [3:0] ofs_w = {i_addr[3:2], 2'b00};
  // Bank select is seen in the dword at 0xC, written through lane 2 only.
  wire       bsel_w = hit_w && (ofs_w == `BHRD_OFS_BANK_SEL_DW);
  // Banks 56..63 answer nothing besides the bank select register.
  wire       rsvd_bank_w = (o_bank_choice_field >= `BHRD_BANK_RSVD_FIRST);
  wire       bank0_w = hit_w && !rsvd_bank_w &&
                       (o_bank_choice_field == `BHRD_BANK_ZERO);
  wire       base_sel_w  = bank0_w && (ofs_w == `BHRD_OFS_BASE_ADDR);
  wire       wmark_sel_w = bank0_w && (ofs_w == `BHRD_OFS_WATERMARK);
  wire       wr_w = i_ce && i_wr;
  wire       wmark_q;

  // ----------------------------------------------------------------------------
  // Watermark register
  // ----------------------------------------------------------------------------
  bhrd_wmark_reg u_wmark (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    // Writes before the base load finishes are refused, as for every register.
    .i_wr       (i_wr && wmark_sel_w && o_load_done),
    .i_lane_hi  (i_be[1]),
    .i_wdata    (i_wdata[`BHRD_WMARK_BIT]),
    .o_sel_2k_r (wmark_q)
  );

  // ----------------------------------------------------------------------------
  // Bank select and base address
  // ----------------------------------------------------------------------------
  // Strap is caught after reset release, never inside the async branch.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bank_choice_field <= {BANK_W{1'b0}};
      o_host_base_address <= `BHRD_BASE_RESET;
      o_load_done         <= 1'b0;
    end else if (i_ce) begin
      if (!o_load_done) begin
        if (!i_eeprom_load_enable_pin) begin
          o_load_done <= 1'b1;
        end else if (i_eeprom_valid) begin
          // Read-only low bits stay zero whatever the EEPROM holds.
          o_host_base_address <= i_eeprom_word0 & `BHRD_BASE_RW_MASK;
          o_load_done         <= 1'b1;
        end
      end else if (wr_w) begin
        // Lanes 0..1 of the dword at 0xC are reserved and left alone.
        if (bsel_w && i_be[2]) begin
          o_bank_choice_field <= i_wdata[16 +: BANK_W];
        end
        // Only the register changes; no EEPROM write path exists.
        if (base_sel_w && i_be[0]) begin
          o_host_base_address[7:5] <= i_wdata[7:5];
        end
        if (base_sel_w && i_be[1]) begin
          o_host_base_address[15:8] <= i_wdata[15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read data and status outputs
  // ----------------------------------------------------------------------------
  // Registered read data gives one cycle of latency; unmapped reads return zero.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata    <= 32'h0000_0000;
      o_hit      <= 1'b0;
      o_wmark_2k <= 1'b0;
    end else if (i_ce) begin
      o_hit      <= hit_w && (i_rd || i_wr);
      o_wmark_2k <= wmark_q;
      if (i_rd && bsel_w) begin
        o_rdata <= {{(16-BANK_W){1'b0}}, o_bank_choice_field, 16'h0000};
      end else if (i_rd && base_sel_w) begin
        o_rdata <= {16'h0000, o_host_base_address};
      end else if (i_rd && wmark_sel_w) begin
        o_rdata <= {19'h00000, wmark_q, 12'h000};
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end
  end

  // No implemented register here has write-one-to-clear bits; the event input
  // is accepted so a later sticky flag can be added with set winning clear.
  wire unused_w = i_wmark_event;
endmodule // bhrd_top

// *** hw/bhrd_wmark_reg.v ***
// Single-bit receive-queue watermark selector register with byte-lane write.
`timescale 1ns/100ps
`include "bhrd_map.vh"
module bhrd_wmark_reg (
  input  wire i_sys_clk,
  input  wire i_nrst,
  input  wire i_ce,
  input  wire i_wr,
  input  wire i_lane_hi,
  input  wire i_wdata,
  output reg  o_sel_2k_r
);
  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // Bit 12 lives in the upper byte, so only an upper-lane write touches it.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sel_2k_r <= `BHRD_WMARK_RESET;
    end else if (i_ce && i_wr && i_lane_hi) begin
      o_sel_2k_r <= i_wdata;
    end
  end
endmodule // bhrd_wmark_reg

// *** sim/bhrd_host.sv ***
// Host processor model: one access at a time, driven and released on falling edges.
`timescale 1ns/100ps
module bhrd_host (input wire logic i_sys_clk, input wire logic [31:0] i_rdata,
  output logic o_wr, o_rd, output logic [3:0] o_be, output logic [15:0] o_addr,
  output logic [31:0] o_wdata);
  initial {o_wr, o_rd, o_be, o_addr, o_wdata} = '0;
  // Released data shows the inverse, so a stale value is never taken by luck.
  task automatic acc(input logic w, logic [15:0] a, logic [3:0] e, logic [31:0] d);
    @(negedge i_sys_clk);
    {o_wr, o_rd, o_addr, o_be, o_wdata} = {w, !w, a, e, d};
    @(negedge i_sys_clk);
    {o_wr, o_rd, o_wdata} = {2'b00, ~d};
  endtask
  // Reserved bits go back exactly as read, with the wanted bits ORed in.
  task automatic rmw(input logic [15:0] a, logic [31:0] m);
    acc(0, a, 4'hf, 0);
    acc(1, a, 4'hf, i_rdata | m);
  endtask
endmodule // bhrd_host

// *** sim/bhrd_monitor.sv ***
// Port checker of the host register decode.
`timescale 1ns/100ps
module bhrd_monitor #(parameter BANK_W = 6) (
  input wire logic i_sys_clk, i_nrst, i_ce, i_wr, i_rd, o_hit, o_load_done,
  input wire logic i_eeprom_load_enable_pin,
  input wire logic [3:0] i_be,
  input wire logic [15:0] i_addr, i_eeprom_word0, o_host_base_address,
  input wire logic [31:0] i_wdata, o_rdata,
  input wire logic [BANK_W-1:0] o_bank_choice_field);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // Address bits 4 to 0 never take part in the claim.
  wire [15:0] base = o_host_base_address;
  wire claim = i_addr[15:5] == base[15:5];
  wire sel = i_ce && o_load_done && claim && i_addr[3:2] == 2'h3;
  sequence s_bank_wr; sel && i_wr && i_be[2]; endsequence
  sequence s_bank_rd; sel && i_rd; endsequence
  a_bank_set: assert property (s_bank_wr |=> o_bank_choice_field == $past(i_wdata[21:16]))
    else $error("bank not set");
  a_bank_read: assert property (s_bank_rd |=> o_rdata == {10'h000, $past(o_bank_choice_field), 16'h0000})
    else $error("bank read");
  a_bank_hold: assert property (!i_wr |=> $stable(o_bank_choice_field))
    else $error("bank moved");
  a_miss_quiet: assert property ((i_wr || i_rd) && !claim |=> !o_hit)
    else $error("miss claimed");
  a_base_low: assert property (base[4:0] == 5'h00)
    else $error("base low bits");
  a_base_reset: assert property ($rose(o_load_done) && !i_eeprom_load_enable_pin |-> base == 16'h0300)
    else $error("base default");
  a_eeprom_load: assert property ($rose(o_load_done) && i_eeprom_load_enable_pin |-> base[15:5] == i_eeprom_word0[15:5])
    else $error("base load");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data stays");
endmodule // bhrd_monitor
bind bhrd_top bhrd_monitor #(.BANK_W(BANK_W)) bhrd_monitor_inst (.*);

// *** sim/bhrd_top_bench.sv ***
// Self-checking bench of the host register decode.
`timescale 1ns/100ps
module bhrd_top_bench;
  logic i_sys_clk = 0, i_nrst = 0, i_ce = 1, i_eeprom_load_enable_pin = 0, i_eeprom_valid = 1;
  logic i_wmark_event = 0, i_wr, i_rd, o_hit, o_wmark_2k, o_load_done;
  logic [3:0] i_be;
  logic [5:0] o_bank_choice_field;
  logic [15:0] i_addr, i_eeprom_word0, o_host_base_address, b = 16'h0300;
  logic [31:0] i_wdata, o_rdata, d;
  int errors = 0, checked = 0, k;
  bhrd_top bhrd_top_inst (.*);
  bhrd_host bhrd_host_inst (.i_sys_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_be(i_be), .o_addr(i_addr), .o_wdata(i_wdata));
  // Clock of 25 ns; inputs change on falling edges only.
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  // Compare one result with the model.
  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) $display("wrong value at %0t: %h, model %h", $time, s, e);
    errors += (s !== e);
  endtask
  // Sole exit of the run.
  task print_verdict(input int miss);
    errors += miss;
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait for the base load.
  task wt;
    for (k = 0; o_load_done !== 1'b1 && k < 50; k++) @(negedge i_sys_clk);
    if (k == 50) print_verdict(1);
  endtask
  initial begin
    void'($urandom(32'h6334));
    i_eeprom_word0 = $urandom;
    repeat (10) @(negedge i_sys_clk);
    i_nrst = 1;
    wt;
    chk(o_host_base_address, 16'h0300);
    chk(o_wmark_2k, 0);
    repeat (12) begin
      d = $urandom;
      bhrd_host_inst.acc(1, b | 16'h000c | {d[1], 1'b0}, d[3:0] | 4'h4, d);
      chk(o_bank_choice_field, d[21:16]);
      bhrd_host_inst.acc(0, b | 16'h000c, 4'hf, 0);
      chk(o_rdata, {10'h000, d[21:16], 16'h0000});
      bhrd_host_inst.acc(0, b, 4'hf, 0);
      chk(o_rdata[15:0], d[21:16] ? 16'h0000 : b);
    end
    bhrd_host_inst.acc(1, b | 16'h000e, 4'h4, 0);
    bhrd_host_inst.rmw(b | 16'h0004, 32'h0000_1000);
    @(negedge i_sys_clk);
    chk(o_wmark_2k, 1);
    d = $urandom;
    bhrd_host_inst.acc(1, b, 4'h3, d);
    chk(o_host_base_address, d[15:0] & 16'hffe0);
    bhrd_host_inst.acc(0, b | 16'h000c, 4'hf, 0);
    chk(o_hit, d[15:5] == b[15:5]);
    b = d[15:0] & 16'hffe0;
    bhrd_host_inst.acc(0, b | 16'h000c, 4'hf, 0);
    chk(o_hit, 1);
    i_nrst = 0;
    i_eeprom_load_enable_pin = 1;
    i_eeprom_valid = 0;
    repeat (10) @(negedge i_sys_clk);
    i_nrst = 1;
    repeat (4) @(negedge i_sys_clk);
    chk(o_load_done, 0);
    chk(o_bank_choice_field, 0);
    i_eeprom_valid = 1;
    wt;
    chk(o_host_base_address, i_eeprom_word0 & 16'hffe0);
    print_verdict(0);
  end
endmodule // bhrd_top_bench
